// ---- rtl/timer_channel.sv ----
// Purpose: one counter channel with count load, latch and read-back capture
// Assumes: count_tick is a one-cycle enable from the top-level divider
// Notes: counting waveform simplified; the count wraps at terminal instead of reloading
module timer_channel
  import interval_timer_pkg::*;
(
  // clock, reset and count tick
  input wire logic clock,
  input wire logic rstn,
  input wire logic count_tick,
  // command strobes
  input wire logic ctrl_we,
  input wire logic [5:0] ctrl_in,
  input wire logic latch_count,
  input wire logic latch_status,
  input wire logic data_we,
  input wire logic data_re,
  input wire logic [7:0] wdata,
  // results
  output logic [7:0] rdata,
  output logic out_level
);
  logic [5:0] ctrl_reg;
  logic [15:0] count_reg;
  logic [15:0] init_reg;
  logic [15:0] olatch_reg;
  logic [7:0] status_reg;
  logic cnt_latched_reg;
  logic st_latched_reg;
  logic null_reg;
  logic load_pend_reg;
  logic wr_msb_reg;
  read_phase_t rphase_reg;
  logic [1:0] acc;
  logic [2:0] mode;
  logic [15:0] view;
  logic [15:0] dec;
  logic [7:0] status_now;

  assign acc = ctrl_reg[5:4];
  assign mode = ctrl_reg[3:1];
  assign view = cnt_latched_reg ? olatch_reg : count_reg;
  assign status_now = {out_level, null_reg, ctrl_reg};

  // bcd-aware decrement, 0 wraps to the top of range
  always_comb
  begin
    dec = count_reg - 16'h0001;
    if (ctrl_reg[0])
    begin
      if (count_reg == 16'h0000)
        dec = 16'h9999;
      else if (count_reg[11:0] == 12'h000)
        dec = {count_reg[15:12] - 4'h1, 12'h999};
      else if (count_reg[7:0] == 8'h00)
        dec = {count_reg[15:8] - 8'h01, 8'h99};
      else if (count_reg[3:0] == 4'h0)
        dec = {count_reg[15:4] - 12'h001, 4'h9};
      else
        dec = count_reg - 16'h0001;
    end
  end

  // control word store; no reset value is promised to software
  always_ff @(posedge clock)
  begin
    if (!rstn)
      ctrl_reg <= CTRL_RESET;
    else if (ctrl_we)
      ctrl_reg <= ctrl_in;
  end

  // count byte writes in the programmed order
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      init_reg <= COUNT_RESET;
      wr_msb_reg <= 1'b0;
      load_pend_reg <= 1'b0;
    end
    else if (ctrl_we)
    begin
      wr_msb_reg <= 1'b0;
      load_pend_reg <= 1'b0;
    end
    else if (data_we)
    begin
      // new count accepted any time after the control word
      if (acc == ACC_LSB)
      begin
        init_reg <= {8'h00, wdata};
        load_pend_reg <= 1'b1;
      end
      else if (acc == ACC_MSB)
      begin
        init_reg <= {wdata, 8'h00};
        load_pend_reg <= 1'b1;
      end
      else if (!wr_msb_reg)
      begin
        init_reg[7:0] <= wdata;
        wr_msb_reg <= 1'b1;
      end
      else
      begin
        init_reg[15:8] <= wdata;
        wr_msb_reg <= 1'b0;
        load_pend_reg <= 1'b1;
      end
    end
    else if (load_pend_reg && count_tick)
      load_pend_reg <= 1'b0;
  end

  // counting element: loads on the next tick after a full count arrives
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      count_reg <= COUNT_RESET;
      null_reg <= 1'b0;
      out_level <= 1'b0;
    end
    else
    begin
      if (ctrl_we)
      begin
        null_reg <= 1'b1;
        out_level <= (ctrl_in[3:1] != 3'b000);
      end
      else if (data_we)
        null_reg <= 1'b1;
      else if (count_tick)
      begin
        if (load_pend_reg)
        begin
          count_reg <= init_reg;
          null_reg <= 1'b0;
        end
        else
        begin
          count_reg <= dec;
          if (count_reg == 16'h0001)
            out_level <= (mode == 3'b000) ? 1'b1 : ~out_level;
        end
      end
    end
  end

  // output latch and status latch; first command wins until read
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      olatch_reg <= COUNT_RESET;
      status_reg <= 8'h00;
      cnt_latched_reg <= 1'b0;
      st_latched_reg <= 1'b0;
      rphase_reg <= RD_LSB;
    end
    else if (ctrl_we)
    begin
      cnt_latched_reg <= 1'b0;
      st_latched_reg <= 1'b0;
      rphase_reg <= RD_LSB;
    end
    else if (data_re)
    begin
      // status goes first, then one or two count bytes
      if (st_latched_reg)
        st_latched_reg <= 1'b0;
      else
        case (rphase_reg)
          RD_LSB:
          begin
            if (acc == ACC_BOTH)
              rphase_reg <= RD_MSB;
            else
              cnt_latched_reg <= 1'b0;
          end
          RD_MSB:
          begin
            rphase_reg <= RD_LSB;
            cnt_latched_reg <= 1'b0;
          end
          default: rphase_reg <= RD_LSB;
        endcase
    end
    else
    begin
      if (latch_count && !cnt_latched_reg)
      begin
        olatch_reg <= count_reg;
        cnt_latched_reg <= 1'b1;
      end
      if (latch_status && !st_latched_reg)
      begin
        status_reg <= status_now;
        st_latched_reg <= 1'b1;
      end
    end
  end

  // read data mux
  always_comb
  begin
    if (st_latched_reg)
      rdata = status_reg;
    else if (acc == ACC_MSB || rphase_reg == RD_MSB)
      rdata = view[15:8];
    else
      rdata = view[7:0];
  end
endmodule

// ---- rtl/interval_timer_pkg.sv ----
// Purpose: shared constants for the interval timer command decoder
// Assumes: 8-bit I/O port access from the expansion bus, one clock
// Notes: port offsets are I/O addresses; the control and read-back ports share an address
package interval_timer_pkg;
  localparam logic [7:0] GRP1_DATA0_ADDR = 8'h40;
  localparam logic [7:0] GRP1_DATA1_ADDR = 8'h41;
  localparam logic [7:0] GRP1_DATA2_ADDR = 8'h42;
  localparam logic [7:0] GRP1_CMD_ADDR = 8'h43;
  localparam logic [7:0] GRP2_DATA0_ADDR = 8'h48;
  localparam logic [7:0] GRP2_DATA2_ADDR = 8'h4A;
  localparam logic [7:0] GRP2_CMD_ADDR = 8'h4B;
  // control word fields
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 6;
  localparam int ACC_HI = 5;
  localparam int ACC_LO = 4;
  localparam int MODE_HI = 3;
  localparam int MODE_LO = 1;
  localparam int BCD_BIT = 0;
  localparam logic [1:0] SEL_READBACK = 2'h3;
  localparam logic [1:0] ACC_LATCH = 2'h0;
  localparam logic [1:0] ACC_LSB = 2'h1;
  localparam logic [1:0] ACC_MSB = 2'h2;
  localparam logic [1:0] ACC_BOTH = 2'h3;
  // read-back fields, both latch bits active low
  localparam int RB_NCOUNT_BIT = 5;
  localparam int RB_NSTATUS_BIT = 4;
  localparam int RB_CNT0_BIT = 1;
  // status byte fields
  localparam int ST_OUT_BIT = 7;
  localparam int ST_NULL_BIT = 6;
  // reset values
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  // read data flow states
  typedef enum logic [2:0] {
    RD_LSB = 3'b001,
    RD_MSB = 3'b010,
    RD_DONE = 3'b100
  } read_phase_t;
endpackage

// ---- rtl/interval_timer_control_readback.sv ----
// Purpose: I/O decode of two timer groups: control words, read-back, data ports
// Assumes: single-cycle io_wr/io_rd strobes on the system clock; five counters present
// Notes: group 2 counter 1 is absent; its slot is never instantiated
//
// Function
// - two write-only 8-bit control word ports
// - bits 7:6 select counter or read-back
// - bits 5:4 byte order or counter latch
// - bits 3:1 counting mode, bit 3 partial
// - bit 0 binary or decimal countdown
// - new count accepted any time after control
// - one count data port per counter
// - control settings undefined after reset
// - reset clears outputs, speaker, request, refresh
// - read-back captures count, mode, output, null
// - read-back bits 3:1 select counters 2..0
// - read-back 00 latches count and status
// - latched count holds until read
// - latches released by port reads or a new control word
// - repeated latches before read are ignored
// - status read first, then count bytes
// - status byte field layout
// - counter latch captures count, repeats ignored
module interval_timer_control_readback
  import interval_timer_pkg::*;
#(
  parameter int TICK_DIV = 8
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // I/O port access
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // speaker gate and system outputs
  input wire logic speaker_gate,
  output logic timer_interrupt_request,
  output logic refresh_request,
  output logic speaker_output,
  output logic port61_bit5,
  output logic [4:0] counter_out
);
  localparam int NCH = 6;
  localparam logic [NCH-1:0] PRESENT = 6'b101111;

  logic [$clog2(TICK_DIV)-1:0] div_reg;
  logic tick_reg;
  logic gate_meta_reg;
  logic gate_sync_reg;
  logic [NCH-1:0] ctrl_we;
  logic [NCH-1:0] latch_cnt;
  logic [NCH-1:0] latch_st;
  logic [NCH-1:0] data_we;
  logic [NCH-1:0] data_re;
  logic [NCH-1:0] outs;
  logic [7:0] ch_rdata [NCH];
  logic [7:0] rd_next;
  logic cmd_g1;
  logic cmd_g2;
  logic [1:0] sel;
  logic [1:0] acc;

  // tick enable for counting; a single clock domain throughout
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= (div_reg == $bits(div_reg)'(TICK_DIV - 1));
      if (div_reg == $bits(div_reg)'(TICK_DIV - 1))
        div_reg <= '0;
      else
        div_reg <= div_reg + 1'b1;
    end
  end

  // speaker gate comes from a pin, so synchronise it
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      gate_meta_reg <= 1'b0;
      gate_sync_reg <= 1'b0;
    end
    else
    begin
      gate_meta_reg <= speaker_gate;
      gate_sync_reg <= gate_meta_reg;
    end
  end

  assign cmd_g1 = io_wr && (io_addr == GRP1_CMD_ADDR);
  assign cmd_g2 = io_wr && (io_addr == GRP2_CMD_ADDR);
  assign sel = io_wdata[SEL_HI:SEL_LO];
  assign acc = io_wdata[ACC_HI:ACC_LO];

  // command decode, per counter slot (group*3 + index)
  always_comb
  begin
    ctrl_we = '0;
    latch_cnt = '0;
    latch_st = '0;
    data_we = '0;
    data_re = '0;
    for (int g = 0; g < 2; g++)
    begin
      if (g == 0 ? cmd_g1 : cmd_g2)
      begin
        if (sel == SEL_READBACK)
        begin
          for (int c = 0; c < 3; c++)
          begin
            if (io_wdata[RB_CNT0_BIT + c])
            begin
              // zero bits latch, so 00 latches both
              latch_cnt[g*3+c] = !io_wdata[RB_NCOUNT_BIT];
              latch_st[g*3+c] = !io_wdata[RB_NSTATUS_BIT];
            end
          end
        end
        else if (acc == ACC_LATCH)
          latch_cnt[g*3+int'(sel)] = 1'b1;
        else
          ctrl_we[g*3+int'(sel)] = 1'b1;
      end
    end
    // count data ports
    if (io_addr == GRP1_DATA0_ADDR)
    begin
      data_we[0] = io_wr;
      data_re[0] = io_rd;
    end
    else if (io_addr == GRP1_DATA1_ADDR)
    begin
      data_we[1] = io_wr;
      data_re[1] = io_rd;
    end
    else if (io_addr == GRP1_DATA2_ADDR)
    begin
      data_we[2] = io_wr;
      data_re[2] = io_rd;
    end
    else if (io_addr == GRP2_DATA0_ADDR)
    begin
      data_we[3] = io_wr;
      data_re[3] = io_rd;
    end
    else if (io_addr == GRP2_DATA2_ADDR)
    begin
      data_we[5] = io_wr;
      data_re[5] = io_rd;
    end
    ctrl_we = ctrl_we & PRESENT;
    latch_cnt = latch_cnt & PRESENT;
    latch_st = latch_st & PRESENT;
  end

  // present counters only; the missing slot reads as zero
  genvar i;
  generate
    for (i = 0; i < NCH; i++)
    begin : g_ch
      if (PRESENT[i])
      begin : g_on
        timer_channel u_ch (
          .clock(clock),
          .rstn(rstn),
          .count_tick(tick_reg),
          .ctrl_we(ctrl_we[i]),
          .ctrl_in(io_wdata[5:0]),
          .latch_count(latch_cnt[i]),
          .latch_status(latch_st[i]),
          .data_we(data_we[i]),
          .data_re(data_re[i]),
          .wdata(io_wdata),
          .rdata(ch_rdata[i]),
          .out_level(outs[i])
        );
      end
      else
      begin : g_off
        assign ch_rdata[i] = 8'h00;
        assign outs[i] = 1'b0;
      end
    end
  endgenerate

  // read data selection; control ports are write-only and read zero
  always_comb
  begin
    rd_next = 8'h00;
    for (int k = 0; k < NCH; k++)
      if (data_re[k])
        rd_next = ch_rdata[k];
  end

  // registered outputs, all cleared by reset
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      io_rdata <= 8'h00;
      counter_out <= 5'h00;
      timer_interrupt_request <= 1'b0;
      refresh_request <= 1'b0;
      speaker_output <= 1'b0;
      port61_bit5 <= 1'b0;
    end
    else
    begin
      io_rdata <= rd_next;
      counter_out <= {outs[5], outs[3], outs[2], outs[1], outs[0]};
      timer_interrupt_request <= outs[0];
      refresh_request <= outs[1];
      speaker_output <= outs[2] & gate_sync_reg;
      port61_bit5 <= outs[2];
    end
  end
endmodule

// ---- testbench/io_host.sv ----
// Purpose: host side of the timer I/O ports
// Assumes: strobes change on the falling edge, one strobe per access
// Notes: released lines show the inverse of the last value
module io_host (
  // clock
  input wire logic clock,
  // I/O port access
  output logic [7:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial
  begin
    io_addr = 8'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // single write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clock);
    io_wr = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask
  // data answers one cycle after the strobe, taken just after it drops
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clock);
    io_rd = 1'b0;
    io_addr = ~a;
    d = io_rdata;
  endtask
  // control word first, then exactly the bytes it announced, unbroken
  task automatic prog(input logic [7:0] cmd, input logic [7:0] port, input logic [7:0] cw,
    input logic [15:0] cnt);
    wr(cmd, cw);
    if (cw[4])
      wr(port, cnt[7:0]);
    if (cw[5])
      wr(port, cnt[15:8]);
  endtask
endmodule

// ---- testbench/interval_timer_chk.sv ----
// Purpose: port assertions for the timer command decoder
// Assumes: one clock, synchronous active-low reset
// Notes: output copies are taken to share one register stage
module interval_timer_chk
  import interval_timer_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // I/O port access
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  // speaker gate and system outputs
  input wire logic speaker_gate,
  input wire logic timer_interrupt_request,
  input wire logic refresh_request,
  input wire logic speaker_output,
  input wire logic port61_bit5,
  input wire logic [4:0] counter_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // a read of either write-only command port
  sequence cmd_read_s;
    io_rd && (io_addr == GRP1_CMD_ADDR || io_addr == GRP2_CMD_ADDR);
  endsequence
  // gate held off long enough to cross the synchroniser
  sequence gate_off_s;
    !speaker_gate [*5];
  endsequence
  rdata_idle_a: assert property (!io_rd |=> io_rdata == 8'h00)
    else $error("read data not idle");
  cmd_read_zero_a: assert property (cmd_read_s |=> io_rdata == 8'h00)
    else $error("command port gave data");
  reset_clear_a: assert property ($rose(rstn) |->
    counter_out == 5'h00 && !timer_interrupt_request && !refresh_request
    && !speaker_output && !port61_bit5)
    else $error("outputs not cleared by reset");
  irq_copy_a: assert property (timer_interrupt_request == counter_out[0])
    else $error("request differs from counter 0");
  refresh_copy_a: assert property (refresh_request == counter_out[1])
    else $error("refresh differs from counter 1");
  port_copy_a: assert property (port61_bit5 == counter_out[2])
    else $error("port bit differs from counter 2");
  speaker_gated_a: assert property (speaker_output |-> port61_bit5)
    else $error("speaker high without counter 2");
  speaker_off_a: assert property (gate_off_s |-> !speaker_output)
    else $error("speaker ignores gate");
endmodule

bind interval_timer_control_readback interval_timer_chk u_chk (
  .clock(clock), .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .speaker_gate(speaker_gate),
  .timer_interrupt_request(timer_interrupt_request), .refresh_request(refresh_request),
  .speaker_output(speaker_output), .port61_bit5(port61_bit5), .counter_out(counter_out)
);

// ---- testbench/testbench.sv ----
// Purpose: self-checking bench for the timer command decoder
// Assumes: host model drives the I/O strobes on the falling edge
// Notes: tick divider shortened to 2 so counts move quickly
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("[FAIL] %0t got %h want %h", $time, got, exp); \
    end \
  end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import interval_timer_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic speaker_gate = 1'b0;
  logic [7:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic speaker_output;
  logic timer_interrupt_request;
  logic refresh_request;
  logic port61_bit5;
  logic [4:0] counter_out;
  int err_total = 0;
  int check_count = 0;
  logic [7:0] ports [5] = '{8'h40, 8'h41, 8'h42, 8'h48, 8'h4A};
  logic [7:0] cw;
  logic [7:0] cmd;
  logic [7:0] s;
  logic [15:0] v1;
  logic [15:0] v2;
  // 100 ns period
  always #50 clock = ~clock;
  interval_timer_control_readback #(.TICK_DIV(2)) u_interval_timer_control_readback (
    .clock(clock), .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .speaker_gate(speaker_gate),
    .timer_interrupt_request(timer_interrupt_request), .refresh_request(refresh_request),
    .speaker_output(speaker_output), .port61_bit5(port61_bit5), .counter_out(counter_out)
  );
  io_host u_io_host (
    .clock(clock), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata)
  );
  // two-byte count, low byte first
  task automatic rd16(input logic [7:0] port, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    u_io_host.rd(port, lo);
    u_io_host.rd(port, hi);
    v = {hi, lo};
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // hang guard
  initial
  begin
    repeat (20000) @(posedge clock);
    err_total++;
    end_of_test();
  end
  // main sequence
  initial
  begin
    repeat (5) @(negedge clock);
    rstn = 1'b1;
    @(negedge clock);
    `CHK(counter_out, 5'h00)
    `CHK(speaker_output, 1'b0)
    `CHK(timer_interrupt_request, 1'b0)
    `CHK(refresh_request, 1'b0)
    `CHK(port61_bit5, 1'b0)
    $display("test reset done");
    // every counter and mode code; no count written, so null stays set
    for (int k = 0; k < 5; k++)
    begin
      for (int m = 0; m < 8; m++)
      begin
        cw = {ports[k][1:0], 2'(m % 3 + 1), 3'(m), m[0]};
        cmd = {ports[k][7:2], 2'b11};
        u_io_host.wr(cmd, cw);
        u_io_host.wr(cmd, 8'hE0 | (8'h02 << ports[k][1:0]));
        u_io_host.rd(ports[k], s);
        `CHK(s[6:0], {1'b1, cw[5:0]})
      end
    end
    $display("test modes done");
    u_io_host.wr(8'h43, 8'hEE);
    for (int k = 0; k < 3; k++)
    begin
      u_io_host.rd(ports[k], s);
      `CHK(s[6:0], 7'h6F)
    end
    u_io_host.rd(8'h43, s);
    `CHK(s, 8'h00)
    $display("test select done");
    // a second latch before the read must keep the older count
    u_io_host.prog(8'h43, 8'h40, 8'h30, 16'h1234);
    repeat (10) @(negedge clock);
    u_io_host.wr(8'h43, 8'h00);
    repeat (40) @(negedge clock);
    u_io_host.wr(8'h43, 8'h00);
    rd16(8'h40, v1);
    u_io_host.wr(8'h43, 8'h00);
    rd16(8'h40, v2);
    `CHK(v1 > v2 + 16'd8, 1'b1)
    `CHK(v1 < 16'h1234, 1'b1)
    u_io_host.wr(8'h43, 8'hC2);
    repeat (40) @(negedge clock);
    u_io_host.wr(8'h43, 8'hC2);
    u_io_host.rd(8'h40, s);
    `CHK(s, 8'h30)
    rd16(8'h40, v1);
    u_io_host.wr(8'h43, 8'hD2);
    rd16(8'h40, v2);
    `CHK(v1 > v2 + 16'd8, 1'b1)
    $display("test latch done");
    // decimal countdown borrows 1000 down to 0999, binary would give 0fff
    u_io_host.prog(8'h4B, 8'h48, 8'h31, 16'h1000);
    repeat (10) @(negedge clock);
    u_io_host.wr(8'h4B, 8'h00);
    rd16(8'h48, v1);
    `CHK(v1[15:4], 12'h099)
    // high byte only: one write loads, one read returns the high byte
    u_io_host.prog(8'h4B, 8'h4A, 8'hA4, 16'h0500);
    repeat (10) @(negedge clock);
    u_io_host.wr(8'h4B, 8'h80);
    u_io_host.rd(8'h4A, s);
    `CHK(s, 8'h04)
    // the missing counter's port answers nothing
    u_io_host.rd(8'h49, s);
    `CHK(s, 8'h00)
    $display("test formats done");
    // usual system setup, then let the speaker run
    u_io_host.prog(8'h43, 8'h40, 8'h36, 16'h0004);
    u_io_host.prog(8'h43, 8'h41, 8'h74, 16'h0006);
    u_io_host.prog(8'h43, 8'h42, 8'hB6, 16'h0004);
    speaker_gate = 1'b1;
    s = 8'h00;
    for (int t = 0; t < 200 && s == 8'h00; t++)
    begin
      @(negedge clock);
      if (speaker_output === 1'b1)
        s = 8'h01;
    end
    `CHK(s, 8'h01)
    speaker_gate = 1'b0;
    repeat (20) @(negedge clock);
    $display("test speaker done");
    end_of_test();
  end
endmodule
